// ==== csrf_core.sv ====
// core special register file: flags, pointers, bank, accumulator, pc latch
// assumes the core drives bus, alu and event inputs on clk_i; memory answers combinationally
`timescale 1ns/1ps
module csrf_core (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cold_rst_i,
   // register port
   input wire csrf_pkg::csrf_bus_type bus_i,
   output logic [7:0] rdata_o,
   // alu and core events
   input wire csrf_pkg::csrf_alu_type alu_i,
   input wire csrf_pkg::csrf_evt_type evt_i,
   input wire logic [7:0] pc_low_i,
   output logic pc_low_we_o,
   output logic [7:0] pc_low_o,
   // indirect memory
   input wire logic [7:0] mem_rdata_i,
   output logic [15:0] mem_addr_o,
   output logic mem_rd_o,
   output logic mem_wr_o,
   output logic mem_prog_o,
   output logic [7:0] mem_wdata_o,
   output logic extra_cycle_o,
   // register views
   output logic [15:0] ptr_first_o,
   output logic [15:0] ptr_second_o,
   output logic [5:0] bank_select_o,
   output logic [7:0] working_accumulator_o,
   output logic [6:0] program_counter_high_latch_o,
   output logic [7:0] flags_o
);
   import csrf_pkg::*;

   logic [7:0] flags_reg, flags_next;
   logic [15:0] p0_reg, p1_reg;
   logic [5:0] bank_reg;
   logic [7:0] wacc_reg;
   logic [6:0] program_counter_high_latch_reg;
   logic [7:0] rdata_reg;
   logic pcl_we_reg;
   logic [7:0] pcl_reg;
   logic [15:0] maddr_reg;
   logic mrd_reg, mwr_reg, mprog_reg, xcyc_reg;
   logic [7:0] mwd_reg;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] bop;
   logic carry_in;

   function automatic logic is_self(input logic [15:0] a);
      is_self = (a == CSRF_IND_LO) || (a == CSRF_IND_HI);
   endfunction : is_self

   wire w_bus = bus_i.wr;
   wire r_bus = bus_i.rd;
   wire sel_ind0 = (bus_i.addr == CSRF_OFF_IND0);
   wire sel_ind1 = (bus_i.addr == CSRF_OFF_IND1);
   wire sel_ind = sel_ind0 | sel_ind1;
   wire [15:0] ind_ptr = sel_ind1 ? p1_reg : p0_reg;
   wire ind_prog = ind_ptr[CSRF_PROG_BIT];
   wire ind_self = is_self(ind_ptr);
   wire ind_rd = r_bus & sel_ind & ~ind_self;
   wire ind_wr = w_bus & sel_ind & ~ind_self & ~ind_prog;
   wire [7:0] ind_data = ind_self ? CSRF_BYTE_RST : mem_rdata_i;

   // flag arithmetic: subtract adds the two's complement of b
   assign bop = (alu_i.op == CSRF_OP_SUB) ? ~alu_i.b : alu_i.b;
   assign carry_in = (alu_i.op == CSRF_OP_SUB);
   assign sum = {1'b0, alu_i.a} + {1'b0, bop} + {8'h00, carry_in};
   assign nib = {1'b0, alu_i.a[3:0]} + {1'b0, bop[3:0]} + {4'h0, carry_in};

   always_comb begin
      flags_next = flags_reg;
      case (alu_i.op)
         CSRF_OP_ADD, CSRF_OP_SUB: begin
            flags_next[CSRF_BIT_Z] = (sum[7:0] == 8'h00);
            flags_next[CSRF_BIT_DC] = nib[4];
            flags_next[CSRF_BIT_C] = sum[8];
         end
         CSRF_OP_LOGIC: begin
            flags_next[CSRF_BIT_Z] = (alu_i.a == 8'h00);
         end
         CSRF_OP_RRC: begin
            flags_next[CSRF_BIT_C] = alu_i.a[0];
         end
         CSRF_OP_RLC: begin
            flags_next[CSRF_BIT_C] = alu_i.a[7];
         end
         default: begin
            flags_next = flags_reg;
         end
      endcase
      if (w_bus && bus_i.addr == CSRF_OFF_FLAGS) begin
         flags_next[2:0] = bus_i.wdata[2:0];
      end
      // core events win over software writes; timeout wins over clear
      if (evt_i.wdt_clear) begin
         flags_next[CSRF_BIT_TO] = 1'b1;
         flags_next[CSRF_BIT_PD] = 1'b1;
      end
      if (evt_i.sleep) begin
         flags_next[CSRF_BIT_TO] = 1'b1;
         flags_next[CSRF_BIT_PD] = 1'b0;
      end
      if (evt_i.wdt_timeout) begin
         flags_next[CSRF_BIT_TO] = 1'b0;
      end
      flags_next[7:5] = 3'h0;
      if (cold_rst_i) begin
         flags_next = CSRF_FLAGS_RST;
      end
   end

   // status flags: async reset is the cold reset; warm resets keep values
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_reg <= CSRF_FLAGS_RST;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // pointers, bank, accumulator, latch
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         p0_reg <= CSRF_PTR_RST;
         p1_reg <= CSRF_PTR_RST;
         bank_reg <= CSRF_BANK_RST;
         wacc_reg <= CSRF_BYTE_RST;
         program_counter_high_latch_reg <= CSRF_PROGRAM_COUNTER_HIGH_LATCH_RST;
      end else if (cold_rst_i) begin
         p0_reg <= CSRF_PTR_RST;
         p1_reg <= CSRF_PTR_RST;
         bank_reg <= CSRF_BANK_RST;
         wacc_reg <= CSRF_BYTE_RST;
         program_counter_high_latch_reg <= CSRF_PROGRAM_COUNTER_HIGH_LATCH_RST;
      end else if (w_bus) begin
         case (bus_i.addr)
            CSRF_OFF_P0L: p0_reg[7:0] <= bus_i.wdata;
            CSRF_OFF_P0H: p0_reg[15:8] <= bus_i.wdata;
            CSRF_OFF_P1L: p1_reg[7:0] <= bus_i.wdata;
            CSRF_OFF_P1H: p1_reg[15:8] <= bus_i.wdata;
            CSRF_OFF_BANK: bank_reg <= bus_i.wdata[5:0];
            CSRF_OFF_WACC: wacc_reg <= bus_i.wdata;
            CSRF_OFF_PROGRAM_COUNTER_HIGH_LATCH: program_counter_high_latch_reg <= bus_i.wdata[6:0];
            default: p0_reg <= p0_reg;
         endcase
      end
   end

   // read mux, one cycle later
   logic [7:0] rd_mux;
   always_comb begin
      case (bus_i.addr)
         CSRF_OFF_IND0, CSRF_OFF_IND1: rd_mux = ind_data;
         CSRF_OFF_PCL: rd_mux = pc_low_i;
         CSRF_OFF_FLAGS: rd_mux = flags_reg;
         CSRF_OFF_P0L: rd_mux = p0_reg[7:0];
         CSRF_OFF_P0H: rd_mux = p0_reg[15:8];
         CSRF_OFF_P1L: rd_mux = p1_reg[7:0];
         CSRF_OFF_P1H: rd_mux = p1_reg[15:8];
         CSRF_OFF_BANK: rd_mux = {2'h0, bank_reg};
         CSRF_OFF_WACC: rd_mux = wacc_reg;
         CSRF_OFF_PROGRAM_COUNTER_HIGH_LATCH: rd_mux = {1'b0, program_counter_high_latch_reg};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= 8'h00;
         pcl_we_reg <= 1'b0;
         pcl_reg <= 8'h00;
         maddr_reg <= 16'h0000;
         mrd_reg <= 1'b0;
         mwr_reg <= 1'b0;
         mprog_reg <= 1'b0;
         mwd_reg <= 8'h00;
         xcyc_reg <= 1'b0;
      end else begin
         rdata_reg <= r_bus ? rd_mux : 8'h00;
         pcl_we_reg <= w_bus && bus_i.addr == CSRF_OFF_PCL;
         pcl_reg <= bus_i.wdata;
         maddr_reg <= ind_prog ? {1'b0, ind_ptr[14:0]} : ind_ptr;
         mrd_reg <= ind_rd;
         mwr_reg <= ind_wr;
         mprog_reg <= ind_prog;
         mwd_reg <= bus_i.wdata;
         xcyc_reg <= (ind_rd | (w_bus & sel_ind)) & ind_prog;
      end
   end

   assign rdata_o = rdata_reg;
   assign pc_low_we_o = pcl_we_reg;
   assign pc_low_o = pcl_reg;
   assign mem_addr_o = maddr_reg;
   assign mem_rd_o = mrd_reg;
   assign mem_wr_o = mwr_reg;
   assign mem_prog_o = mprog_reg;
   assign mem_wdata_o = mwd_reg;
   assign extra_cycle_o = xcyc_reg;
   assign ptr_first_o = p0_reg;
   assign ptr_second_o = p1_reg;
   assign bank_select_o = bank_reg;
   assign working_accumulator_o = wacc_reg;
   assign program_counter_high_latch_o = program_counter_high_latch_reg;
   assign flags_o = flags_reg;

   property p_sleep_flags;
      @(posedge clk_i) disable iff (rst_i)
      (evt_i.sleep && !evt_i.wdt_timeout && !cold_rst_i) |=> (flags_o[4:3] == 2'b10);
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

   property p_timeout;
      @(posedge clk_i) disable iff (rst_i)
      (evt_i.wdt_timeout && !cold_rst_i) |=> !flags_o[4];
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout flag not cleared");

   property p_cold;
      @(posedge clk_i) disable iff (rst_i)
      cold_rst_i |=> (flags_o == 8'h18) && (ptr_first_o == 16'h0000);
   endproperty
   a_cold: assert property (p_cold) else $error("cold reset values wrong");

   property p_add_carry;
      @(posedge clk_i) disable iff (rst_i)
      (alu_i.op == CSRF_OP_ADD && !cold_rst_i && !(bus_i.wr && bus_i.addr == 5'h03))
      |=> flags_o[0] == (({1'b0, $past(alu_i.a)} + {1'b0, $past(alu_i.b)}) > 9'h0ff);
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("carry wrong");

   property p_sub_borrow;
      @(posedge clk_i) disable iff (rst_i)
      (alu_i.op == CSRF_OP_SUB && !cold_rst_i && !(bus_i.wr && bus_i.addr == 5'h03))
      |=> flags_o[0] == ($past(alu_i.a) >= $past(alu_i.b));
   endproperty
   a_sub_borrow: assert property (p_sub_borrow) else $error("borrow polarity wrong");

   property p_byte_keep;
      @(posedge clk_i) disable iff (rst_i)
      (bus_i.wr && bus_i.addr == 5'h04 && !cold_rst_i)
      |=> ptr_first_o[15:8] == $past(ptr_first_o[15:8]);
   endproperty
   a_byte_keep: assert property (p_byte_keep) else $error("other byte changed");

   property p_prog_nowrite;
      @(posedge clk_i) disable iff (rst_i)
      (bus_i.wr && bus_i.addr == 5'h00 && ptr_first_o[15]) |=> !mem_wr_o && extra_cycle_o;
   endproperty
   a_prog_nowrite: assert property (p_prog_nowrite) else $error("program write passed");

   property p_self_zero;
      @(posedge clk_i) disable iff (rst_i)
      (bus_i.rd && bus_i.addr == 5'h01 && ptr_second_o == 16'h0000) |=> rdata_o == 8'h00;
   endproperty
   a_self_zero: assert property (p_self_zero) else $error("self read not zero");

   property p_p0_high_keep;
      @(posedge clk_i) disable iff (rst_i)
      (bus_i.wr && bus_i.addr == 5'h05 && !cold_rst_i) |=> ptr_first_o[7:0] == $past(ptr_first_o[7:0]);
   endproperty
   a_p0_high_keep: assert property (p_p0_high_keep) else $error("low byte changed");

   property p_p1_low_keep;
      @(posedge clk_i) disable iff (rst_i)
      (bus_i.wr && bus_i.addr == 5'h06 && !cold_rst_i)
      |=> ptr_second_o[15:8] == $past(ptr_second_o[15:8]);
   endproperty
   a_p1_low_keep: assert property (p_p1_low_keep) else $error("high byte changed");

   property p_p1_high_keep;
      @(posedge clk_i) disable iff (rst_i)
      (bus_i.wr && bus_i.addr == 5'h07 && !cold_rst_i) |=> ptr_second_o[7:0] == $past(ptr_second_o[7:0]);
   endproperty
   a_p1_high_keep: assert property (p_p1_high_keep) else $error("low byte changed");

   property p_rotate_right;
      @(posedge clk_i) disable iff (rst_i)
      (alu_i.op == CSRF_OP_RRC && !cold_rst_i && !(bus_i.wr && bus_i.addr == 5'h03))
      |=> flags_o[0] == $past(alu_i.a[0]);
   endproperty
   a_rotate_right: assert property (p_rotate_right) else $error("rotate right carry wrong");

   property p_rotate_left;
      @(posedge clk_i) disable iff (rst_i)
      (alu_i.op == CSRF_OP_RLC && !cold_rst_i && !(bus_i.wr && bus_i.addr == 5'h03))
      |=> flags_o[0] == $past(alu_i.a[7]);
   endproperty
   a_rotate_left: assert property (p_rotate_left) else $error("rotate left carry wrong");

   property p_add_zero;
      @(posedge clk_i) disable iff (rst_i)
      (alu_i.op == CSRF_OP_ADD && !cold_rst_i && !(bus_i.wr && bus_i.addr == 5'h03))
      |=> flags_o[2] == (8'($past(alu_i.a) + $past(alu_i.b)) == 8'h00);
   endproperty
   a_add_zero: assert property (p_add_zero) else $error("zero flag wrong");

   property p_add_digit;
      @(posedge clk_i) disable iff (rst_i)
      (alu_i.op == CSRF_OP_ADD && !cold_rst_i && !(bus_i.wr && bus_i.addr == 5'h03))
      |=> flags_o[1] == (({1'b0, $past(alu_i.a[3:0])} + {1'b0, $past(alu_i.b[3:0])}) > 5'h0f);
   endproperty
   a_add_digit: assert property (p_add_digit) else $error("digit carry wrong");

   property p_wdt_clear;
      @(posedge clk_i) disable iff (rst_i)
      (evt_i.wdt_clear && !evt_i.sleep && !evt_i.wdt_timeout && !cold_rst_i)
      |=> flags_o[4:3] == 2'b11;
   endproperty
   a_wdt_clear: assert property (p_wdt_clear) else $error("clear flags wrong");

   property p_pcl_write;
      @(posedge clk_i) disable iff (rst_i)
      (bus_i.wr && bus_i.addr == 5'h02) |=> pc_low_we_o && (pc_low_o == $past(bus_i.wdata));
   endproperty
   a_pcl_write: assert property (p_pcl_write) else $error("counter low write lost");

   property p_pcl_read;
      @(posedge clk_i) disable iff (rst_i)
      (bus_i.rd && bus_i.addr == 5'h02) |=> rdata_o == $past(pc_low_i);
   endproperty
   a_pcl_read: assert property (p_pcl_read) else $error("counter low read wrong");

   property p_bank_write;
      @(posedge clk_i) disable iff (rst_i)
      (bus_i.wr && bus_i.addr == 5'h08 && !cold_rst_i) |=> bank_select_o == $past(bus_i.wdata[5:0]);
   endproperty
   a_bank_write: assert property (p_bank_write) else $error("bank write lost");

   property p_program_counter_high_latch_write;
      @(posedge clk_i) disable iff (rst_i)
      (bus_i.wr && bus_i.addr == 5'h0a && !cold_rst_i) |=> program_counter_high_latch_o == $past(bus_i.wdata[6:0]);
   endproperty
   a_program_counter_high_latch_write: assert property (p_program_counter_high_latch_write) else $error("latch write lost");

   property p_self_nowrite;
      @(posedge clk_i) disable iff (rst_i)
      (bus_i.wr && bus_i.addr == 5'h01 && ptr_second_o == 16'h0001) |=> !mem_wr_o;
   endproperty
   a_self_nowrite: assert property (p_self_nowrite) else $error("self write passed");

   property p_prog_addr;
      @(posedge clk_i) disable iff (rst_i)
      (bus_i.rd && bus_i.addr == 5'h00 && ptr_first_o[15]) |=> mem_prog_o && !mem_addr_o[15];
   endproperty
   a_prog_addr: assert property (p_prog_addr) else $error("program address wrong");

endmodule : csrf_core

// ==== csrf_pkg.sv ====
// constants and carrier types of the core special register file
// assumes one core clock; the core drives the register port and flag events
// Behaviour
// - counter-low register reads and writes pc bits 7:0
// - time-out set by power-up/clear/sleep, cleared by timeout
// - power-down set by power-up/clear, cleared by sleep
// - cold reset sets both flags, otherwise event-dependent
// - arithmetic flags clear on cold reset, else kept
// - zero flag follows zero result
// - digit carry is carry out of bit 3
// - carry is carry out of bit 7
// - subtract adds two's complement, borrow inverted
// - rotates load carry with shifted-out bit
// - first pointer 16 bits, reset zero
// - second pointer 16 bits, reset zero
// - pointers addressable as high and low bytes
// - bank select holds six address bits
// - counter-high latch seven bits, reset zero
// - indirect data targets pointed location; self reads zero
// - pointer msb set reads program memory, extra cycle
package csrf_pkg;
   localparam logic [4:0] CSRF_OFF_IND0 = 5'h00;
   localparam logic [4:0] CSRF_OFF_IND1 = 5'h01;
   localparam logic [4:0] CSRF_OFF_PCL = 5'h02;
   localparam logic [4:0] CSRF_OFF_FLAGS = 5'h03;
   localparam logic [4:0] CSRF_OFF_P0L = 5'h04;
   localparam logic [4:0] CSRF_OFF_P0H = 5'h05;
   localparam logic [4:0] CSRF_OFF_P1L = 5'h06;
   localparam logic [4:0] CSRF_OFF_P1H = 5'h07;
   localparam logic [4:0] CSRF_OFF_BANK = 5'h08;
   localparam logic [4:0] CSRF_OFF_WACC = 5'h09;
   localparam logic [4:0] CSRF_OFF_PROGRAM_COUNTER_HIGH_LATCH = 5'h0a;
   localparam int CSRF_BIT_TO = 4;
   localparam int CSRF_BIT_PD = 3;
   localparam int CSRF_BIT_Z = 2;
   localparam int CSRF_BIT_DC = 1;
   localparam int CSRF_BIT_C = 0;
   localparam logic [7:0] CSRF_FLAGS_RST = 8'h18;
   localparam logic [15:0] CSRF_PTR_RST = 16'h0000;
   localparam logic [7:0] CSRF_BYTE_RST = 8'h00;
   localparam logic [5:0] CSRF_BANK_RST = 6'h00;
   localparam logic [6:0] CSRF_PROGRAM_COUNTER_HIGH_LATCH_RST = 7'h00;
   localparam logic [15:0] CSRF_IND_LO = 16'h0000;
   localparam logic [15:0] CSRF_IND_HI = 16'h0001;
   localparam int CSRF_PROG_BIT = 15;
   // alu operation presented by the core for flag update
   typedef enum logic [2:0] {
      CSRF_OP_NONE = 3'h0,
      CSRF_OP_LOGIC = 3'h1,
      CSRF_OP_ADD = 3'h3,
      CSRF_OP_SUB = 3'h2,
      CSRF_OP_RRC = 3'h6,
      CSRF_OP_RLC = 3'h7
   } csrf_op_type;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } csrf_bus_type;
   typedef struct packed {
      csrf_op_type op;
      logic [7:0] a;
      logic [7:0] b;
   } csrf_alu_type;
   typedef struct packed {
      logic wdt_clear;
      logic sleep;
      logic wdt_timeout;
   } csrf_evt_type;
endpackage : csrf_pkg

// ==== csrf_mem_model.sv ====
// far-side model: indirect data memory seen through the pointers
// assumes csrf_core samples memory data in the cycle of the read strobe
`timescale 1ns/1ps
module csrf_mem_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register file side
   input wire csrf_pkg::csrf_bus_type bus_i,
   input wire logic [15:0] ptr_first_i,
   input wire logic [15:0] ptr_second_i,
   // memory data
   output logic [7:0] mem_rdata_o
);
   import csrf_pkg::*;
   logic [7:0] noise_reg;
   logic [15:0] sel_ptr;
   logic ind_rd;
   assign ind_rd = bus_i.rd && (bus_i.addr == CSRF_OFF_IND0 || bus_i.addr == CSRF_OFF_IND1);
   assign sel_ptr = (bus_i.addr == CSRF_OFF_IND1) ? ptr_second_i : ptr_first_i;
   // addressed data while read, changing junk otherwise
   assign mem_rdata_o = ind_rd ? (~sel_ptr[7:0] ^ sel_ptr[15:8]) : noise_reg;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) noise_reg <= 8'h35;
      else noise_reg <= noise_reg + 8'h4b;
   end
endmodule : csrf_mem_model

// ==== core_special_register_file_test.sv ====
// self-checking bench of the core special register file
// assumes csrf_core and csrf_mem_model; random data from an lfsr seeded 81
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin error_cnt++; \
   $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module core_special_register_file_test;
   import csrf_pkg::*;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic cold_rst_i = 1'h0;
   csrf_bus_type bus = '0;
   csrf_alu_type alu = '0;
   csrf_evt_type evt = '0;
   logic [7:0] pc_low = 8'h00;
   logic [7:0] mem_rdata, rdata, pc_low_o, mem_wdata, wacc, flags, got, a, b;
   logic [15:0] mem_addr, ptr0, ptr1, e;
   logic pc_low_we, mem_rd, mem_wr, mem_prog, extra;
   logic [5:0] bank;
   logic [6:0] program_counter_high_latch;
   logic [7:0] lfsr_reg = 8'h51;
   int error_cnt = 0;
   int n_compared = 0;
   csrf_op_type ops [5] = '{CSRF_OP_ADD, CSRF_OP_SUB, CSRF_OP_LOGIC, CSRF_OP_RRC, CSRF_OP_RLC};
   logic [7:0] ca [4] = '{8'h08, 8'h5a, 8'hff, 8'h00};
   logic [7:0] cb [4] = '{8'h08, 8'h5a, 8'h01, 8'h01};
   logic [2:0] evs [3] = '{3'h4, 3'h2, 3'h1};
   logic [1:0] tps [3] = '{2'h3, 2'h2, 2'h0};
   csrf_op_type o;
   always #2.5 clk_i = ~clk_i;
   csrf_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .cold_rst_i(cold_rst_i), .bus_i(bus),
      .rdata_o(rdata), .alu_i(alu), .evt_i(evt), .pc_low_i(pc_low), .pc_low_we_o(pc_low_we),
      .pc_low_o(pc_low_o), .mem_rdata_i(mem_rdata), .mem_addr_o(mem_addr), .mem_rd_o(mem_rd),
      .mem_wr_o(mem_wr), .mem_prog_o(mem_prog), .mem_wdata_o(mem_wdata), .extra_cycle_o(extra),
      .ptr_first_o(ptr0), .ptr_second_o(ptr1), .bank_select_o(bank),
      .working_accumulator_o(wacc), .program_counter_high_latch_o(program_counter_high_latch), .flags_o(flags));
   csrf_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .ptr_first_i(ptr0),
      .ptr_second_i(ptr1), .mem_rdata_o(mem_rdata));
   function automatic logic [7:0] rnd();
      lfsr_reg = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      return lfsr_reg;
   endfunction : rnd
   function automatic logic [7:0] mdata(input logic [15:0] p);
      return ~p[7:0] ^ p[15:8];
   endfunction : mdata
   // expected zero, digit carry, carry of add or subtract
   function automatic logic [2:0] arith(input csrf_op_type op, input logic [7:0] x, y);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] v;
      v = (op == CSRF_OP_SUB) ? ~y : y;
      s = {1'h0, x} + {1'h0, v} + {8'h00, op == CSRF_OP_SUB};
      h = {1'h0, x[3:0]} + {1'h0, v[3:0]} + {4'h0, op == CSRF_OP_SUB};
      return {s[7:0] == 8'h00, h[4], s[8]};
   endfunction : arith
   task automatic wr(input logic [4:0] ad, input logic [7:0] d);
      @(posedge clk_i);
      bus <= {1'h1, 1'h0, ad, d};
      @(posedge clk_i);
      bus <= '0;
      #1;
   endtask : wr
   task automatic rd(input logic [4:0] ad);
      @(posedge clk_i);
      bus <= {1'h0, 1'h1, ad, 8'h00};
      @(posedge clk_i);
      bus <= '0;
      #1;
      got = rdata;
   endtask : rd
   task automatic run_op(input csrf_op_type op, input logic [7:0] x, y);
      @(posedge clk_i);
      alu <= {op, x, y};
      @(posedge clk_i);
      alu <= {CSRF_OP_NONE, 16'h0000};
      #1;
   endtask : run_op
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      `CHK("reset flags", CSRF_FLAGS_RST, flags)
      `CHK("reset ptrs", 39'h0, {ptr0, ptr1, program_counter_high_latch})
      pc_low <= 8'ha7;
      rd(CSRF_OFF_PCL);
      `CHK("pcl read", 8'ha7, got)
      wr(CSRF_OFF_PCL, 8'h3c);
      `CHK("pcl write", 9'h13c, {pc_low_we, pc_low_o})
      for (int i = 0; i < 30; i++) begin
         a = (i < 4) ? ca[i] : rnd();
         b = (i < 4) ? cb[i] : rnd();
         o = (i < 4) ? ops[i % 2] : ops[i % 5];
         e = {ptr0[15:8], a};
         wr(CSRF_OFF_P0L, a);
         `CHK("ptr0", e, ptr0)
         e = {b, ptr1[7:0]};
         wr(CSRF_OFF_P1H, b);
         `CHK("ptr1", e, ptr1)
         wr(CSRF_OFF_BANK, a);
         wr(CSRF_OFF_PROGRAM_COUNTER_HIGH_LATCH, b);
         `CHK("bank program_counter_high_latch", {a[5:0], b[6:0]}, {bank, program_counter_high_latch})
         wr(CSRF_OFF_WACC, b);
         rd(CSRF_OFF_WACC);
         `CHK("wacc", b, got)
         run_op(o, a, b);
         if (o == CSRF_OP_ADD || o == CSRF_OP_SUB)
            `CHK("arith", arith(o, a, b), flags[2:0])
         else if (o == CSRF_OP_LOGIC)
            `CHK("zero", a == 8'h00, flags[2])
         else
            `CHK("rotate", (o == CSRF_OP_RRC) ? a[0] : a[7], flags[0])
      end
      got = flags;
      wr(CSRF_OFF_FLAGS, 8'hfd);
      `CHK("flag write", {got[7:3], 3'h5}, flags)
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_i);
         evt <= evs[i];
         @(posedge clk_i);
         evt <= '0;
         #1;
         `CHK("flag event", {tps[i], 3'h5}, flags[4:0])
      end
      @(posedge clk_i);
      cold_rst_i <= 1'h1;
      @(posedge clk_i);
      cold_rst_i <= 1'h0;
      #1;
      `CHK("cold flags", CSRF_FLAGS_RST, flags)
      `CHK("cold regs", 39'h0, {ptr0, ptr1, program_counter_high_latch})
      wr(CSRF_OFF_P0H, 8'h12);
      wr(CSRF_OFF_P0L, 8'h34);
      rd(CSRF_OFF_IND0);
      `CHK("ind read", mdata(16'h1234), got)
      `CHK("ind addr", {2'h2, 16'h1234}, {mem_rd, mem_prog, mem_addr})
      wr(CSRF_OFF_IND0, 8'h9e);
      `CHK("ind write", 9'h19e, {mem_wr, mem_wdata})
      wr(CSRF_OFF_P1L, 8'h01);
      rd(CSRF_OFF_IND1);
      `CHK("self read", 8'h00, got)
      wr(CSRF_OFF_IND1, 8'h77);
      `CHK("self write", 1'h0, mem_wr)
      wr(CSRF_OFF_P0H, 8'h81);
      wr(CSRF_OFF_P0L, 8'h23);
      rd(CSRF_OFF_IND0);
      `CHK("prog read", mdata(16'h8123), got)
      `CHK("prog addr", {2'h3, 16'h0123}, {mem_prog, extra, mem_addr})
      wr(CSRF_OFF_IND0, 8'h5c);
      `CHK("prog write", 1'h0, mem_wr)
      rd(5'h1f);
      `CHK("unmapped", 8'h00, got)
      summarize();
   end
endmodule : core_special_register_file_test
